//--- hdl/wsc_core.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "wsc_map.svh"

module wsc_core #(
  parameter int unsigned WDT_PERIOD_CYC = `WSC_US_TO_CYC(`WSC_WDT_PERIOD_US),
  parameter int unsigned DRT_PERIOD_CYC = `WSC_US_TO_CYC(`WSC_DRT_PERIOD_US)
) (
  // clock and power-on reset
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // register port
  input  wire logic [`WSC_ADDR_W-1:0]     reg_addr,
  input  wire logic [`WSC_DATA_W-1:0]     reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [`WSC_DATA_W-1:0]     reg_rdata,
  // core commands
  input  wire logic                       clear_watchdog_cmd,
  input  wire logic                       sleep_cmd,
  input  wire logic                       prog_mode,
  // external reset pin, input only
  input  wire logic                       master_reset_pin_n,
  // timer module side
  input  wire logic                       timer_src_tick,
  input  wire logic                       timer_write,
  output logic                            timer_inc,
  output logic                            timer_source_sel,
  output logic                            timer_edge_sel,
  // program memory read path
  input  wire logic                       pm_rd,
  input  wire logic [`WSC_PM_ADDR_W-1:0]  pm_addr,
  input  wire logic [`WSC_DATA_W-1:0]     pm_raw_data,
  output logic      [`WSC_DATA_W-1:0]     pm_rdata,
  // device control and status
  output logic                            device_reset,
  output logic                            osc_drive_en,
  output logic                            io_hold,
  output logic                            sleeping,
  output wsc_pkg::wsc_osc_t               oscillator_select,
  output logic                            code_protect_on,
  output logic                            timeout_flag_n,
  output logic                            powerdown_flag_n
);

  localparam int unsigned WDT_W = $clog2(WDT_PERIOD_CYC + 1);
  localparam int unsigned DRT_W = $clog2(DRT_PERIOD_CYC + 1);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_PERIOD_CYC - 1);
  localparam logic [DRT_W-1:0] DRT_LAST = DRT_W'(DRT_PERIOD_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state

  wsc_pkg::wsc_state_t          state_q, state_d;
  logic [`WSC_CFG_IMPL_W-1:0]   cfg_q;
  logic [`WSC_DATA_W-1:0]       uid_q [4];
  logic [7:0]                   option_q;
  logic                         to_n_q, to_n_d;
  logic                         pd_n_q, pd_n_d;
  logic [WDT_W-1:0]             wdt_cnt_q;
  logic [7:0]                   psc_q;
  logic [DRT_W-1:0]             drt_cnt_q;
  logic                         timer_inc_q;
  logic [`WSC_DATA_W-1:0]       reg_rdata_q;
  logic [`WSC_DATA_W-1:0]       pm_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  // true when the low 'shift' bits of the count are all ones
  function automatic logic ratio_hit(input logic [7:0] cnt, input logic [3:0] shift);
    logic [7:0] mask;
    mask = ~(8'hFF << shift);
    return (cnt & mask) == mask;
  endfunction

  wire logic       running      = (state_q == wsc_pkg::ST_RUN);
  wire logic       asleep       = (state_q == wsc_pkg::ST_SLEEP);
  wire logic       in_reset     = (state_q == wsc_pkg::ST_PIN_HOLD) ||
                                  (state_q == wsc_pkg::ST_RESET_HOLD);
  wire logic       wdt_enabled  = cfg_q[`WSC_CFG_WATCHDOG_ENABLE_FUSE_BIT];
  wire logic       owner_wdt    = option_q[`WSC_OPT_PSA_BIT];
  wire logic [2:0] ps_ratio     = option_q[`WSC_OPT_PS_LSB +: 3];
  wire logic       clr_cmd      = running && clear_watchdog_cmd;
  wire logic       slp_cmd      = running && sleep_cmd;

  // watchdog base counter runs in both run and sleep
  wire logic       wdt_live     = wdt_enabled && (running || asleep);
  wire logic       wdt_clear    = in_reset || clr_cmd || slp_cmd;
  wire logic       base_tick    = wdt_live && (wdt_cnt_q == WDT_LAST);

  // shared prescaler: source and clear follow the owner bit
  wire logic       psc_src_tick = owner_wdt ? base_tick
                                            : (running && timer_src_tick);
  wire logic       psc_clear    = in_reset ||
                                  (owner_wdt && (clr_cmd || slp_cmd)) ||
                                  (!owner_wdt && timer_write);
  wire logic       wdt_post_hit = ratio_hit(psc_q, {1'b0, ps_ratio});
  wire logic       tmr_pre_hit  = ratio_hit(psc_q, 4'({1'b0, ps_ratio}) + 4'h1);
  wire logic       wdt_timeout  = owner_wdt ? (base_tick && wdt_post_hit)
                                            : base_tick;
  wire logic       tmr_fire     = !owner_wdt && psc_src_tick && tmr_pre_hit && !psc_clear;

  // device reset sources; the pin is only sensed, never driven
  wire logic       pin_reset    = !master_reset_pin_n;
  wire logic       dev_rst_evt  = pin_reset || wdt_timeout;

  // register port decode
  wire logic       hit_option   = (reg_addr == `WSC_REG_OPTION);
  wire logic       hit_status   = (reg_addr == `WSC_REG_STATUS);
  wire logic       hit_config   = (reg_addr == `WSC_REG_CONFIG);
  wire logic       hit_uid      = (reg_addr >= `WSC_REG_UID0) &&
                                  (reg_addr <= `WSC_REG_UID3);
  wire logic [1:0] uid_idx      = reg_addr[1:0];
  wire logic       wr_option    = reg_wr && hit_option && !in_reset;
  wire logic       wr_config    = reg_wr && hit_config && prog_mode;
  wire logic       wr_uid       = reg_wr && hit_uid && prog_mode;

  wire logic [`WSC_DATA_W-1:0] status_word =
    (`WSC_DATA_W'(to_n_q) << `WSC_STAT_TO_BIT) | (`WSC_DATA_W'(pd_n_q) << `WSC_STAT_PD_BIT);
  wire logic [`WSC_DATA_W-1:0] config_word = {`WSC_CFG_UNIMPL, cfg_q};

  // option reads as zero: it is write-only
  wire logic [`WSC_DATA_W-1:0] reg_read_mux =
    hit_status               ? status_word      :
    (hit_config && prog_mode) ? config_word     :
    (hit_uid && prog_mode)    ? uid_q[uid_idx]  :
                                `WSC_DATA_W'h000;

  // protection keeps the low block readable for boot vectors
  wire logic       cp_active    = !cfg_q[`WSC_CFG_CP_BIT];
  wire logic       pm_blocked   = cp_active && (pm_addr > `WSC_PROT_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing of run, sleep and reset hold

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      wsc_pkg::ST_RUN: begin
        if (dev_rst_evt) begin
          state_d = pin_reset ? wsc_pkg::ST_PIN_HOLD : wsc_pkg::ST_RESET_HOLD;
        end else if (slp_cmd) begin
          state_d = wsc_pkg::ST_SLEEP;
        end
      end
      wsc_pkg::ST_SLEEP: begin
        // nothing else wakes the core
        if (dev_rst_evt) begin
          state_d = pin_reset ? wsc_pkg::ST_PIN_HOLD : wsc_pkg::ST_RESET_HOLD;
        end
      end
      wsc_pkg::ST_PIN_HOLD: begin
        if (!pin_reset) begin
          state_d = wsc_pkg::ST_RESET_HOLD;
        end
      end
      wsc_pkg::ST_RESET_HOLD: begin
        if (pin_reset) begin
          state_d = wsc_pkg::ST_PIN_HOLD;
        end else if (drt_cnt_q == DRT_LAST) begin
          state_d = wsc_pkg::ST_RUN;
        end
      end
    endcase
  end

  // flag updates; a time-out wins over a same-cycle command
  always_comb begin
    to_n_d = to_n_q;
    pd_n_d = pd_n_q;
    if (wdt_timeout && (running || asleep)) begin
      to_n_d = 1'b0;
    end else if (slp_cmd) begin
      to_n_d = 1'b1;
      pd_n_d = 1'b0;
    end else if (clr_cmd) begin
      to_n_d = 1'b1;
      pd_n_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flops

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= wsc_pkg::ST_RESET_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end else begin
      to_n_q <= to_n_d;
      pd_n_q <= pd_n_d;
    end
  end

  // reset hold timer restarts on each entry from a reset source
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drt_cnt_q <= '0;
    end else if (state_q != wsc_pkg::ST_RESET_HOLD || pin_reset) begin
      drt_cnt_q <= '0;
    end else if (drt_cnt_q != DRT_LAST) begin
      drt_cnt_q <= drt_cnt_q + DRT_W'(1);
    end
  end

  // watchdog base counter; held at zero while disabled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_cnt_q <= '0;
    end else if (wdt_clear || !wdt_live || base_tick) begin
      wdt_cnt_q <= '0;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + WDT_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      psc_q <= 8'h00;
    end else if (psc_clear || wr_option) begin
      psc_q <= 8'h00;
    end else if (psc_src_tick) begin
      psc_q <= psc_q + 8'h01;
    end
  end

  // option returns to its reset value on every device reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      option_q <= `WSC_OPTION_RST;
    end else if (in_reset) begin
      option_q <= `WSC_OPTION_RST;
    end else if (wr_option) begin
      option_q <= reg_wdata[7:0];
    end
  end

  // fuses change only from program mode, whatever the protection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= `WSC_CFG_RST;
    end else if (wr_config) begin
      cfg_q <= reg_wdata[`WSC_CFG_IMPL_W-1:0];
    end
  end

  // full width is stored; the low-nibble convention is the programmer's
  for (genvar i = 0; i < 4; i++) begin : g_uid
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        uid_q[i] <= `WSC_UID_RST;
      end else if (wr_uid && (uid_idx == 2'(i))) begin
        uid_q[i] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_inc_q <= 1'b0;
    end else begin
      timer_inc_q <= tmr_fire;
    end
  end

  // read data stands for exactly one cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= reg_read_mux;
    end else begin
      reg_rdata_q <= '0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pm_rdata_q <= '0;
    end else if (pm_rd) begin
      pm_rdata_q <= pm_blocked ? `WSC_DATA_W'h000 : pm_raw_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata         = reg_rdata_q;
  assign pm_rdata          = pm_rdata_q;
  assign timer_inc         = timer_inc_q;
  assign timer_source_sel  = option_q[`WSC_OPT_TCS_BIT];
  assign timer_edge_sel    = option_q[`WSC_OPT_TSE_BIT];
  assign device_reset      = in_reset;
  assign sleeping          = asleep;
  assign osc_drive_en      = !asleep;
  assign io_hold           = asleep;
  assign oscillator_select = wsc_pkg::wsc_osc_t'(cfg_q[`WSC_CFG_OSC_LSB +: 2]);
  assign code_protect_on   = cp_active;
  assign timeout_flag_n    = to_n_q;
  assign powerdown_flag_n  = pd_n_q;

endmodule // wsc_core

`default_nettype wire

//--- inc/wsc_map.svh
`ifndef WSC_MAP_SVH
`define WSC_MAP_SVH

// register port geometry
`define WSC_ADDR_W        4
`define WSC_DATA_W        12

// register offsets
`define WSC_REG_OPTION    4'h0
`define WSC_REG_STATUS    4'h1
`define WSC_REG_CONFIG    4'h2
`define WSC_REG_UID0      4'h4
`define WSC_REG_UID3      4'h7

// option register fields and reset value
`define WSC_OPTION_RST    8'h3F
`define WSC_OPT_TCS_BIT   5
`define WSC_OPT_TSE_BIT   4
`define WSC_OPT_PSA_BIT   3
`define WSC_OPT_PS_LSB    0

// status fields
`define WSC_STAT_TO_BIT   4
`define WSC_STAT_PD_BIT   3

// configuration word fields
`define WSC_CFG_CP_BIT    3
`define WSC_CFG_WATCHDOG_ENABLE_FUSE_BIT  2
`define WSC_CFG_OSC_LSB   0
`define WSC_CFG_IMPL_W    4
`define WSC_CFG_RST       4'hF
`define WSC_CFG_UNIMPL    8'hFF
`define WSC_UID_RST       12'hFFF

// program memory protection
`define WSC_PM_ADDR_W     11
`define WSC_PROT_LIMIT    11'h03F

// timing
`define WSC_CLK_KHZ       25000
`define WSC_WDT_PERIOD_US 18000
`define WSC_DRT_PERIOD_US 18000
`define WSC_US_TO_CYC(us) (((us) * `WSC_CLK_KHZ) / 1000)

`endif

//--- inc/wsc_pkg.sv
package wsc_pkg;

  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL  = 2'h0,
    OSC_STANDARD_CRYSTAL   = 2'h1,
    OSC_HIGH_SPEED_CRYSTAL = 2'h2,
    OSC_RC                 = 2'h3
  } wsc_osc_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_PIN_HOLD,
    ST_RESET_HOLD
  } wsc_state_t;

endpackage

//--- testbench/test_watchdog_sleep_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "wsc_map.svh"

module test_watchdog_sleep_config;
  localparam int unsigned WDT = 20;
  localparam int unsigned RESET_HOLD_TIMER = 10;
  typedef struct packed {logic [3:0] addr; logic [11:0] wdata; logic [11:0] rdata;} wsc_row_t;

  logic        core_clk = 1'b0, sys_rst = 1'b1;
  logic [3:0]  reg_addr = '0;
  logic [11:0] reg_wdata = '0, reg_rdata, pm_raw_data = '0, pm_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, pm_rd = 1'b0, prog_mode = 1'b0;
  logic        clear_watchdog_cmd = 1'b0, sleep_cmd = 1'b0, master_reset_pin_n = 1'b1;
  logic        timer_src_tick = 1'b0, timer_write = 1'b0, timer_inc;
  logic        timer_source_sel, timer_edge_sel, device_reset, osc_drive_en, io_hold;
  logic        sleeping, code_protect_on, timeout_flag_n, powerdown_flag_n;
  logic [10:0] pm_addr = '0;
  wsc_pkg::wsc_osc_t oscillator_select;
  int          bad_count = 0, compares = 0;
  wsc_row_t    rows [8] = '{'{`WSC_REG_CONFIG, 12'h000, 12'hFF0},
    '{`WSC_REG_CONFIG, 12'h001, 12'hFF1}, '{`WSC_REG_CONFIG, 12'h00E, 12'hFFE},
    '{`WSC_REG_CONFIG, 12'h00B, 12'hFFB}, '{`WSC_REG_UID0, 12'hFF5, 12'hFF5},
    '{4'h5, 12'hFFA, 12'hFFA}, '{`WSC_REG_UID3, 12'h0C3, 12'h0C3}, '{4'h3, 12'h123, 12'h000}};

  wsc_core #(.WDT_PERIOD_CYC(WDT), .DRT_PERIOD_CYC(RESET_HOLD_TIMER)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clear_watchdog_cmd(clear_watchdog_cmd), .sleep_cmd(sleep_cmd), .prog_mode(prog_mode),
    .master_reset_pin_n(master_reset_pin_n), .timer_src_tick(timer_src_tick),
    .timer_write(timer_write), .timer_inc(timer_inc), .timer_source_sel(timer_source_sel),
    .timer_edge_sel(timer_edge_sel), .pm_rd(pm_rd), .pm_addr(pm_addr),
    .pm_raw_data(pm_raw_data), .pm_rdata(pm_rdata), .device_reset(device_reset),
    .osc_drive_en(osc_drive_en), .io_hold(io_hold), .sleeping(sleeping),
    .oscillator_select(oscillator_select), .code_protect_on(code_protect_on),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n));

  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [11:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic pm(input logic [10:0] a, input logic [11:0] raw, input logic [11:0] exp);
    @(posedge core_clk);
    pm_addr <= a;
    pm_raw_data <= raw;
    pm_rd <= 1'b1;
    @(posedge core_clk);
    pm_rd <= 1'b0;
    #1 chk(pm_rdata, exp);
  endtask
  task automatic clr;
    @(posedge core_clk);
    clear_watchdog_cmd <= 1'b1;
    @(posedge core_clk);
    clear_watchdog_cmd <= 1'b0;
  endtask
  task automatic go_sleep;
    @(posedge core_clk);
    sleep_cmd <= 1'b1;
    @(posedge core_clk);
    sleep_cmd <= 1'b0;
    #1 chk({sleeping, io_hold, osc_drive_en}, 12'h6);
    chk({timeout_flag_n, powerdown_flag_n}, 12'h2);
  endtask
  // bounded wait on the reset output, a hang shows as a mismatch
  task automatic wait_rst(input logic lvl, input int lim);
    for (int i = 0; i < lim && device_reset !== lvl; i++) cyc(1);
    chk(device_reset, lvl);
  endtask
  // ratio 2 in toggles: one tick every other cycle
  task automatic ticks(input int n, input int exp);
    int got;
    got = 0;
    repeat (2 * n + 3) begin
      @(posedge core_clk);
      timer_src_tick <= (n > 0) ? !timer_src_tick : 1'b0;
      n = (timer_src_tick) ? n - 1 : n;
      #1 got += (timer_inc === 1'b1);
    end
    chk(got, exp);
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    chk({device_reset, timeout_flag_n, powerdown_flag_n, sleeping}, 12'hE);
    chk(oscillator_select, 12'h3);
    chk(code_protect_on, 12'h0);
    repeat (18) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(RESET_HOLD_TIMER - 2);
    chk(device_reset, 12'h1);
    cyc(4);
    chk(device_reset, 12'h0);
    $display("test reset done");
    rd(`WSC_REG_STATUS, 12'h018);
    rd(`WSC_REG_OPTION, 12'h000);
    @(posedge core_clk);
    prog_mode <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata);
      if (rows[i].addr == `WSC_REG_CONFIG) begin
        cyc(1);
        chk(oscillator_select, rows[i].wdata[1:0]);
        chk(code_protect_on, !rows[i].wdata[3]);
      end
    end
    @(posedge core_clk);
    prog_mode <= 1'b0;
    rd(`WSC_REG_UID0, 12'h000);
    rd(`WSC_REG_CONFIG, 12'h000);
    rd(4'hF, 12'h000);
    @(posedge core_clk);
    prog_mode <= 1'b1;
    $display("test registers done");
    go_sleep;
    cyc(100);
    chk(sleeping, 12'h1);
    @(posedge core_clk);
    master_reset_pin_n <= 1'b0;
    cyc(5);
    chk({device_reset, sleeping}, 12'h2);
    @(posedge core_clk);
    master_reset_pin_n <= 1'b1;
    wait_rst(1'b0, RESET_HOLD_TIMER + 50);
    // pin wake keeps both flags from sleep entry
    rd(`WSC_REG_STATUS, 12'h010);
    $display("test pin wake done");
    for (int p = 0; p < 3; p++) begin
      wr(`WSC_REG_OPTION, 12'h020 | p);
      ticks(8, 4 >> p);
    end
    chk({timer_source_sel, timer_edge_sel}, 12'h2);
    // a timer write must drop the three counts already taken
    wr(`WSC_REG_OPTION, 12'h021);
    ticks(3, 0);
    @(posedge core_clk);
    timer_write <= 1'b1;
    @(posedge core_clk);
    timer_write <= 1'b0;
    ticks(3, 0);
    wr(`WSC_REG_OPTION, 12'h018);
    ticks(8, 0);
    chk({timer_source_sel, timer_edge_sel}, 12'h1);
    $display("test prescaler done");
    wr(`WSC_REG_CONFIG, 12'h007);
    cyc(1);
    chk(code_protect_on, 12'h1);
    pm(11'h03F, 12'hABC, 12'hABC);
    pm(11'h040, 12'hABC, 12'h000);
    pm(11'h7FF, 12'h555, 12'h000);
    rd(`WSC_REG_CONFIG, 12'hFF7);
    wr(`WSC_REG_UID0, 12'hFFE);
    rd(`WSC_REG_UID0, 12'hFFE);
    wr(`WSC_REG_CONFIG, 12'h00F);
    // watchdog runs at 1:1 here, keep it well away from its period
    clr;
    pm(11'h040, 12'hABC, 12'hABC);
    $display("test protection done");
    clr;
    wr(`WSC_REG_OPTION, 12'h000);
    repeat (10) begin
      cyc(8);
      clr;
    end
    chk(device_reset, 12'h0);
    wait_rst(1'b1, WDT + 5);
    wait_rst(1'b0, RESET_HOLD_TIMER + 50);
    // last clear set the power-down flag, time-out cleared its own
    rd(`WSC_REG_STATUS, 12'h008);
    cyc(200);
    chk(device_reset, 12'h0);
    // ratio 1:2: no time-out after one base period, one after two
    wr(`WSC_REG_OPTION, 12'h009);
    clr;
    cyc(30);
    chk(device_reset, 12'h0);
    wait_rst(1'b1, 15);
    wait_rst(1'b0, RESET_HOLD_TIMER + 50);
    $display("test clear and time-out done");
    wr(`WSC_REG_OPTION, 12'h008);
    clr;
    cyc(12);
    go_sleep;
    cyc(14);
    chk(sleeping, 12'h1);
    wait_rst(1'b1, 15);
    chk(sleeping, 12'h0);
    wait_rst(1'b0, RESET_HOLD_TIMER + 50);
    rd(`WSC_REG_STATUS, 12'h000);
    $display("test sleep time-out done");
    summarize;
  end

  // whole run is about 800 cycles, so 25000 leaves ample room
  initial begin
    #1000000;
    bad_count++;
    summarize;
  end
endmodule // test_watchdog_sleep_config

`default_nettype wire

//--- testbench/wsc_core_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "wsc_map.svh"

module wsc_core_props #(
  parameter int unsigned WDT_PERIOD_CYC = 20,
  parameter int unsigned DRT_PERIOD_CYC = 10
) (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      sys_rst,
  // commands and pin
  input wire logic                      clear_watchdog_cmd,
  input wire logic                      sleep_cmd,
  input wire logic                      master_reset_pin_n,
  // program memory
  input wire logic                      pm_rd,
  input wire logic [`WSC_PM_ADDR_W-1:0] pm_addr,
  input wire logic [`WSC_DATA_W-1:0]    pm_raw_data,
  input wire logic [`WSC_DATA_W-1:0]    pm_rdata,
  // status
  input wire logic                      device_reset,
  input wire logic                      osc_drive_en,
  input wire logic                      io_hold,
  input wire logic                      sleeping,
  input wire logic                      code_protect_on,
  input wire logic                      timeout_flag_n,
  input wire logic                      powerdown_flag_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // hold length counted only with the pin released, so a pin reset
  // measures from its release
  logic [31:0] hold_cnt_q;
  logic [31:0] hold_cnt_d;
  assign hold_cnt_d = (device_reset && master_reset_pin_n) ? hold_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) hold_cnt_q <= 32'h0;
    else hold_cnt_q <= hold_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_sleep_entry_flags: assert property (
    sleep_cmd && !device_reset && !sleeping && master_reset_pin_n |=>
    (sleeping && !powerdown_flag_n && timeout_flag_n) || (device_reset && !timeout_flag_n))
    else $error("sleep entry flags wrong");
  a_sleep_pins_held: assert property (
    io_hold == sleeping && osc_drive_en == !sleeping)
    else $error("hold or oscillator drive not tied to sleep");
  a_clear_sets_flags: assert property (
    clear_watchdog_cmd && !sleep_cmd && !device_reset && !sleeping && master_reset_pin_n
    |=> (timeout_flag_n && powerdown_flag_n) || device_reset)
    else $error("clear command flags wrong");
  a_protect_blocks: assert property (
    pm_rd && code_protect_on && pm_addr > `WSC_PROT_LIMIT |=> pm_rdata == '0)
    else $error("protected word leaked");
  a_low_words_open: assert property (
    pm_rd && pm_addr <= `WSC_PROT_LIMIT |=> pm_rdata == $past(pm_raw_data))
    else $error("low word not passed through");
  a_wake_by_reset: assert property (
    $fell(sleeping) |-> device_reset)
    else $error("left sleep without reset");
  a_hold_length: assert property (
    $fell(device_reset) |->
    hold_cnt_q >= DRT_PERIOD_CYC - 1 && hold_cnt_q <= DRT_PERIOD_CYC + 1)
    else $error("reset hold length wrong");
  a_timeout_flag_clr: assert property (
    $rose(device_reset) && $past(master_reset_pin_n) && master_reset_pin_n |-> !timeout_flag_n)
    else $error("time-out reset kept flag set");
  a_pin_resets: assert property (
    !master_reset_pin_n [*3] |-> device_reset)
    else $error("pin low without reset");
endmodule // wsc_core_props

bind wsc_core wsc_core_props #(
  .WDT_PERIOD_CYC(WDT_PERIOD_CYC), .DRT_PERIOD_CYC(DRT_PERIOD_CYC)
) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .clear_watchdog_cmd(clear_watchdog_cmd),
  .sleep_cmd(sleep_cmd), .master_reset_pin_n(master_reset_pin_n), .pm_rd(pm_rd),
  .pm_addr(pm_addr), .pm_raw_data(pm_raw_data), .pm_rdata(pm_rdata),
  .device_reset(device_reset), .osc_drive_en(osc_drive_en), .io_hold(io_hold),
  .sleeping(sleeping), .code_protect_on(code_protect_on),
  .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n)
);

`default_nettype wire
